// File: verilog/loop_config_pkg.sv
// shared constants and carrier types for the loop configuration registers
package loop_config_pkg;

   // register access
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [ADDR_W-1:0] ZERO_RES_OFFSET  = 12'h01D;
   localparam logic [ADDR_W-1:0] PUMP_CUR_OFFSET  = 12'h0F0;
   localparam logic [ADDR_W-1:0] FB_DIV_OFFSET    = 12'h0F1;
   localparam logic [ADDR_W-1:0] CONTROL_OFFSET   = 12'h0F2;

   // reset values
   localparam logic [3:0] ZERO_RES_RESET = 4'h0;
   localparam logic [7:0] PUMP_CUR_RESET = 8'h80;
   localparam logic [7:0] FB_DIV_RESET   = 8'h1C;
   localparam logic [7:0] CONTROL_RESET  = 8'h0B;

   // field positions
   localparam int ZERO_RES_MSB   = 3;
   localparam int FB_FINE_MSB    = 7;
   localparam int FB_FINE_LSB    = 6;
   localparam int FB_COARSE_MSB  = 5;
   localparam int FB_COARSE_LSB  = 0;
   localparam int CTL_LOCK_PD    = 7;
   localparam int CTL_RESERVED   = 6;
   localparam int CTL_DOUBLER    = 5;
   localparam int CTL_SW_ABL     = 4;
   localparam int CTL_ABL_MSB    = 3;
   localparam int CTL_ABL_LSB    = 2;
   localparam int CTL_MODE_MSB   = 1;
   localparam int CTL_MODE_LSB   = 0;

   // zero resistor values in kilohms
   localparam logic [9:0] RES_KOHM_0   = 10'h373;
   localparam logic [9:0] RES_KOHM_1   = 10'h2A5;
   localparam logic [9:0] RES_KOHM_2   = 10'h155;
   localparam logic [9:0] RES_KOHM_3   = 10'h087;
   localparam logic [9:0] RES_KOHM_LOW = 10'h00A;
   localparam logic [3:0] RES_EXT_CODE = 4'h8;

   // antibacklash width codes
   localparam logic [1:0] ABL_MIN  = 2'h0;
   localparam logic [1:0] ABL_HIGH = 2'h2;

   // pump current scale, tenths of a microamp per step
   localparam int PUMP_STEP_TENTHS_UA = 35;
   localparam int PUMP_FULL_UA        = 900;

   typedef enum logic [1:0] {
      PUMP_TRISTATE,
      PUMP_UP,
      PUMP_DOWN,
      PUMP_NORMAL
   } pump_mode_t;

   typedef struct packed {
      logic              write;
      logic              read;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } reg_access_t;

   typedef struct packed {
      logic [9:0] zeroResKohm;
      logic       zeroResExternal;
      logic       zeroResValid;
      logic [7:0] pumpCurrent;
      logic [7:0] feedbackDivide;
      logic       feedbackLegal;
      logic       lockDetectPowerDown;
      logic       refDoubler;
      logic [1:0] antibacklashWidth;
      pump_mode_t pumpMode;
   } loop_config_t;

endpackage : loop_config_pkg

// File: verilog/pll_loop_config_registers.sv
// configuration registers for the input loop resistor and the output loop
`timescale 1ns/100ps

module pll_loop_config_registers (
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          rst,
   // register access from the serial control port
   input  loop_config_pkg::reg_access_t       access,
   output logic [loop_config_pkg::DATA_W-1:0] readData,
   output logic                               readValid,
   // settings toward the analog loop circuits
   output loop_config_pkg::loop_config_t      loopConfig
);
   import loop_config_pkg::*;

   logic [3:0]        zeroRes_reg;
   logic [7:0]        pumpCur_reg;
   logic [7:0]        fbDiv_reg;
   logic              lockPd_reg;
   logic              doubler_reg;
   logic              swAbl_reg;
   logic [1:0]        ablField_reg;
   logic [1:0]        pumpMode_reg;
   logic [DATA_W-1:0] readData_reg;
   logic              readValid_reg;
   loop_config_t      config_reg;
   loop_config_t      config_next;

   logic wrZeroRes;
   logic wrPumpCur;
   logic wrFbDiv;
   logic wrControl;

   // decodes one register offset against the access address
   function automatic logic hit(input reg_access_t a,
                                input logic [ADDR_W-1:0] offset);
      hit = (a.addr == offset);
   endfunction : hit

   // resistor code to kilohms; codes above the external code are undefined
   function automatic logic [9:0] resKohm(input logic [3:0] code);
      unique case (code)
         4'h0:    resKohm = RES_KOHM_0;
         4'h1:    resKohm = RES_KOHM_1;
         4'h2:    resKohm = RES_KOHM_2;
         4'h3:    resKohm = RES_KOHM_3;
         4'h4,
         4'h5,
         4'h6,
         4'h7:    resKohm = RES_KOHM_LOW;
         default: resKohm = 10'h000;
      endcase
   endfunction : resKohm

   // true when the fine count is allowed for the coarse count
   function automatic logic divLegal(input logic [5:0] coarse,
                                     input logic [1:0] fine);
      if (coarse < 6'h04) begin
         divLegal = 1'b0;
      end else if (coarse == 6'h04) begin
         divLegal = (fine <= 2'h1);
      end else if (coarse <= 6'h06) begin
         divLegal = (fine <= 2'h2);
      end else begin
         divLegal = 1'b1;
      end
   endfunction : divLegal

   assign wrZeroRes = access.write && hit(access, ZERO_RES_OFFSET);
   assign wrPumpCur = access.write && hit(access, PUMP_CUR_OFFSET);
   assign wrFbDiv   = access.write && hit(access, FB_DIV_OFFSET);
   assign wrControl = access.write && hit(access, CONTROL_OFFSET);

   // upper four bits are reserved and never stored
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         zeroRes_reg <= ZERO_RES_RESET;
      end else if (wrZeroRes) begin
         zeroRes_reg <= access.data[ZERO_RES_MSB:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pumpCur_reg <= PUMP_CUR_RESET;
      end else if (wrPumpCur) begin
         pumpCur_reg <= access.data;
      end
   end

   // illegal fine/coarse pairs are stored as written and only flagged;
   // clamping would hide the software error from readback
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fbDiv_reg <= FB_DIV_RESET;
      end else if (wrFbDiv) begin
         fbDiv_reg <= access.data;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lockPd_reg   <= CONTROL_RESET[CTL_LOCK_PD];
         doubler_reg  <= CONTROL_RESET[CTL_DOUBLER];
         pumpMode_reg <= CONTROL_RESET[CTL_MODE_MSB:CTL_MODE_LSB];
      end else if (wrControl) begin
         lockPd_reg   <= access.data[CTL_LOCK_PD];
         doubler_reg  <= access.data[CTL_DOUBLER];
         pumpMode_reg <= access.data[CTL_MODE_MSB:CTL_MODE_LSB];
      end
   end

   // bit 6 is reserved: not stored, reads back zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         swAbl_reg <= CONTROL_RESET[CTL_SW_ABL];
      end else if (wrControl) begin
         swAbl_reg <= access.data[CTL_SW_ABL];
      end
   end

   // handing width control to software starts from the minimum, whatever
   // the same write carries in bits 3:2
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ablField_reg <= CONTROL_RESET[CTL_ABL_MSB:CTL_ABL_LSB];
      end else if (wrControl) begin
         if (!swAbl_reg && access.data[CTL_SW_ABL]) begin
            ablField_reg <= ABL_MIN;
         end else begin
            ablField_reg <= access.data[CTL_ABL_MSB:CTL_ABL_LSB];
         end
      end
   end

   // read answer one cycle after the request; unmapped offsets read zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         readData_reg <= 8'h00;
      end else if (access.read) begin
         if (hit(access, ZERO_RES_OFFSET)) begin
            readData_reg <= {4'h0, zeroRes_reg};
         end else if (hit(access, PUMP_CUR_OFFSET)) begin
            readData_reg <= pumpCur_reg;
         end else if (hit(access, FB_DIV_OFFSET)) begin
            readData_reg <= fbDiv_reg;
         end else if (hit(access, CONTROL_OFFSET)) begin
            readData_reg <= {lockPd_reg, 1'b0, doubler_reg, swAbl_reg,
                             ablField_reg, pumpMode_reg};
         end else begin
            readData_reg <= 8'h00;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         readValid_reg <= 1'b0;
      end else begin
         readValid_reg <= access.read;
      end
   end

   // analog settings follow the stored registers one cycle later
   always_comb begin
      config_next = '0;
      config_next.zeroResKohm     = resKohm(zeroRes_reg);
      config_next.zeroResExternal = (zeroRes_reg == RES_EXT_CODE);
      config_next.zeroResValid    = (zeroRes_reg <= RES_EXT_CODE);
      config_next.pumpCurrent     = pumpCur_reg;
      config_next.feedbackDivide  =
         {fbDiv_reg[FB_COARSE_MSB:FB_COARSE_LSB], 2'h0}
         + {6'h00, fbDiv_reg[FB_FINE_MSB:FB_FINE_LSB]};
      config_next.feedbackLegal   =
         divLegal(fbDiv_reg[FB_COARSE_MSB:FB_COARSE_LSB],
                  fbDiv_reg[FB_FINE_MSB:FB_FINE_LSB]);
      config_next.lockDetectPowerDown = lockPd_reg;
      config_next.refDoubler          = doubler_reg;
      config_next.antibacklashWidth   =
         swAbl_reg ? ablField_reg : ABL_HIGH;
      config_next.pumpMode            = pump_mode_t'(pumpMode_reg);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         config_reg <= '0;
         config_reg.zeroResKohm       <= RES_KOHM_0;
         config_reg.zeroResValid      <= 1'b1;
         config_reg.pumpCurrent       <= PUMP_CUR_RESET;
         config_reg.feedbackDivide    <= 8'h70;
         config_reg.feedbackLegal     <= 1'b1;
         config_reg.antibacklashWidth <= ABL_HIGH;
         config_reg.pumpMode          <= PUMP_NORMAL;
      end else begin
         config_reg <= config_next;
      end
   end

   assign readData  = readData_reg;
   assign readValid = readValid_reg;
   assign loopConfig = config_reg;

endmodule : pll_loop_config_registers

// File: sim/pll_loop_config_registers_asserts.sv
// assertion checker for the loop configuration register ports
`timescale 1ns/100ps
module pll_loop_config_registers_asserts (
   // clock and reset
   input logic                               clock,
   input logic                               rst,
   // register access and settings
   input loop_config_pkg::reg_access_t       access,
   input logic [loop_config_pkg::DATA_W-1:0] readData,
   input logic                               readValid,
   input loop_config_pkg::loop_config_t      loopConfig
);
   import loop_config_pkg::*;
   logic       swAbl_reg;
   logic [7:0] dataDly1_reg;
   logic [7:0] dataDly2_reg;
   logic       wrCtl;
   logic       wrZero;
   assign wrCtl = access.write && access.addr == CONTROL_OFFSET;
   assign wrZero = access.write && access.addr == ZERO_RES_OFFSET;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // settings land two edges after the write, so the data is kept that long
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dataDly1_reg <= 8'h00;
         dataDly2_reg <= 8'h00;
      end else begin
         dataDly1_reg <= access.data;
         dataDly2_reg <= dataDly1_reg;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) swAbl_reg <= CONTROL_RESET[CTL_SW_ABL];
      else if (wrCtl) swAbl_reg <= access.data[CTL_SW_ABL];
   end
   a_pump_current: assert property (
      access.write && access.addr == PUMP_CUR_OFFSET |=> ##1
      loopConfig.pumpCurrent == dataDly2_reg) else $error("pump current");
   a_divide_value: assert property (
      access.write && access.addr == FB_DIV_OFFSET |=> ##1
      loopConfig.feedbackDivide ==
         {dataDly2_reg[5:0], 2'b00} + {6'h00, dataDly2_reg[7:6]})
      else $error("divide value");
   a_lock_detect: assert property (wrCtl |=> ##1
      loopConfig.lockDetectPowerDown == dataDly2_reg[7])
      else $error("lock pd");
   a_ref_doubler: assert property (wrCtl |=> ##1
      loopConfig.refDoubler == dataDly2_reg[5]) else $error("doubler");
   a_forced_width: assert property (wrCtl && !access.data[4] |=> ##1
      loopConfig.antibacklashWidth == ABL_HIGH) else $error("forced width");
   a_width_min: assert property (
      wrCtl && access.data[4] && !swAbl_reg |=> ##1
      loopConfig.antibacklashWidth == ABL_MIN) else $error("width not min");
   a_width_programmed: assert property (
      wrCtl && access.data[4] && swAbl_reg |=> ##1
      loopConfig.antibacklashWidth == dataDly2_reg[3:2]) else $error("width");
   a_pump_mode: assert property (wrCtl |=> ##1
      loopConfig.pumpMode == dataDly2_reg[1:0]) else $error("pump mode");
   a_zero_external: assert property (
      wrZero && access.data[3:0] == RES_EXT_CODE |=> ##1
      loopConfig.zeroResExternal && loopConfig.zeroResValid)
      else $error("external");
   a_zero_low: assert property (
      wrZero && access.data[3:2] == 2'b01 |=> ##1
      loopConfig.zeroResKohm == RES_KOHM_LOW) else $error("low resistor");
   a_reserved_read: assert property (
      access.read && access.addr == ZERO_RES_OFFSET |=>
      readValid && readData[7:4] == 4'h0) else $error("reserved bits");
   c_width_load: cover property (wrCtl && access.data[4] && !swAbl_reg);
   c_read: cover property (access.read ##1 readValid);
   c_external: cover property (wrZero && access.data[3:0] == RES_EXT_CODE);
endmodule : pll_loop_config_registers_asserts

bind pll_loop_config_registers pll_loop_config_registers_asserts u_asserts (
   .clock(clock), .rst(rst), .access(access), .readData(readData),
   .readValid(readValid), .loopConfig(loopConfig));

// File: sim/pll_loop_config_registers_tb.sv
// self-checking bench for the loop configuration registers
`timescale 1ns/100ps
module pll_loop_config_registers_tb;
   import loop_config_pkg::*;
   logic         clock = 1'b0;
   logic         rst = 1'b1;
   reg_access_t  access = '0;
   logic [7:0]   readData;
   logic         readValid;
   loop_config_t cfgOut;
   int           failures = 0;
   int           checks = 0;
   logic [31:0]  seed = 32'd45;
   logic [31:0]  r;
   logic [7:0]   zr = 8'h00, pc = 8'h80, fb = 8'h1C, ctl = 8'h0B;
   logic [11:0]  offs [6] = '{12'h01D, 12'h0F0, 12'h0F1, 12'h0F2, 12'h0F3,
                              12'h000};
   logic [7:0]   divs [11] = '{8'h04, 8'h44, 8'h84, 8'h05, 8'h85, 8'hC5, 8'hC6,
                               8'h07, 8'hC7, 8'hFF, 8'h03};
   always #5 clock = ~clock;
   pll_loop_config_registers u_dut (.clock(clock), .rst(rst), .access(access),
      .readData(readData), .readValid(readValid), .loopConfig(cfgOut));
   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xorshift
   function automatic loop_config_t expCfg();
      int kohm [9] = '{883, 677, 341, 135, 10, 10, 10, 10, 0};
      int coarse = fb[5:0];
      int fine = fb[7:6];
      loop_config_t c = '0;
      c.zeroResKohm = 10'(zr <= 8 ? kohm[zr] : 0);
      c.zeroResExternal = zr == 8;
      c.zeroResValid = zr <= 8;
      c.pumpCurrent = pc;
      c.feedbackDivide = 8'(4 * coarse + fine);
      c.feedbackLegal = coarse >= 7 || (coarse >= 5 && fine <= 2)
                        || (coarse == 4 && fine <= 1);
      c.lockDetectPowerDown = ctl[7];
      c.refDoubler = ctl[5];
      c.antibacklashWidth = ctl[4] ? ctl[3:2] : ABL_HIGH;
      c.pumpMode = pump_mode_t'(ctl[1:0]);
      return c;
   endfunction : expCfg
   task automatic cmpByte(logic [7:0] got, logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: read %h expected %h", $time, got, exp);
      end
   endtask : cmpByte
   task automatic cmpCfg();
      checks++;
      if (cfgOut !== expCfg()) begin
         failures++;
         $display("Error at %0t: settings %h expected %h", $time, cfgOut,
                  expCfg());
      end
   endtask : cmpCfg
   task automatic wr(logic [11:0] a, logic [7:0] d);
      @(posedge clock);
      access <= '{1'b1, 1'b0, a, d};
      @(posedge clock);
      access <= '0;
      case (a)
         ZERO_RES_OFFSET: zr = {4'h0, d[3:0]};
         PUMP_CUR_OFFSET: pc = d;
         FB_DIV_OFFSET:   fb = d;
         CONTROL_OFFSET:  ctl = (d[4] && !ctl[4]) ? (d & 8'hB3) : (d & 8'hBF);
         default: ;
      endcase
      @(posedge clock);
      #1 cmpCfg();
   endtask : wr
   task automatic rd(logic [11:0] a);
      @(posedge clock);
      access <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clock);
      access <= '0;
      #1 cmpByte({7'h00, readValid}, 8'h01);
      case (a)
         ZERO_RES_OFFSET: cmpByte(readData, zr);
         PUMP_CUR_OFFSET: cmpByte(readData, pc);
         FB_DIV_OFFSET:   cmpByte(readData, fb);
         CONTROL_OFFSET:  cmpByte(readData, ctl);
         default:         cmpByte(readData, 8'h00);
      endcase
   endtask : rd
   task automatic wrRd(logic [11:0] a, logic [7:0] d);
      wr(a, d);
      rd(a);
   endtask : wrRd
   task automatic conclude();
      if (failures == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   // the whole run is well under this; a hang counts against the design
   initial begin
      #200us;
      failures++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      #1 cmpCfg();
      foreach (offs[i]) rd(offs[i]);
      for (int i = 0; i < 16; i++)
         wrRd(ZERO_RES_OFFSET, 8'(i) | 8'hF0);
      foreach (divs[i]) wrRd(FB_DIV_OFFSET, divs[i]);
      wrRd(PUMP_CUR_OFFSET, 8'hFF);
      wrRd(CONTROL_OFFSET, 8'h0F);
      wrRd(CONTROL_OFFSET, 8'hFD);
      wrRd(CONTROL_OFFSET, 8'h3C);
      for (int i = 0; i < 4; i++) wrRd(CONTROL_OFFSET, 8'(i) | 8'h14);
      wrRd(CONTROL_OFFSET, 8'hA0);
      wrRd(12'h0F3, 8'hFF);
      repeat (60) begin
         r = xorshift();
         wrRd(offs[r[10:8] % 6], r[7:0]);
      end
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      {zr, pc, fb, ctl} = 32'h00801C0B;
      #1 cmpCfg();
      conclude();
   end
endmodule : pll_loop_config_registers_tb
